// *** slow_port_defines.vh ***
// register offsets, field positions and fixed values of the slow-port echo path
`ifndef SLOW_PORT_DEFINES_VH
`define SLOW_PORT_DEFINES_VH
`define ADDR_W 16
`define OFS_RX_CMD 16'h0000
`define OFS_RX_QSTS 16'h0004
`define OFS_TX_LEN 16'h0008
`define OFS_OFFLOAD_CMD 16'h000c
`define OFS_USER_CMD 16'h0010
`define OFS_USER_RST 16'h0014
`define OFS_LOCAL_IP 16'h0018
`define OFS_IRQ_STS 16'h001c
`define OFS_IRQ_MASK 16'h0020
`define RX_BUF_BASE 16'h1000
`define TX_BUF_BASE 16'h2000
`define BUF_SEL_MSB 15
`define BUF_SEL_LSB 11
`define RX_EN_BIT 0
`define RX_ACK_BIT 1
`define QSTS_EMPTY_BIT 15
`define BUSY_BIT 0
`define CONN_ON_BIT 2
`define LINK_UP_BIT 16
`define USER_RST_BIT 0
`define TX_BUSY_BIT 15
`define IRQ_RX_FRAME 0
`define IRQ_TX_DONE 1
`define IRQ_RX_DROP 2
`define HDR_LIMIT 6'd38
`define ETYPE_HI 8'h08
`define ETYPE_LO 8'h00
`define IP_VER_HL 8'h45
`define IP_PROTO_ICMP 8'h01
`define ICMP_ECHO_REQ 8'h08
`define ICMP_CODE_ZERO 8'h00
`define POS_ETYPE 6'd12
`define POS_VER 6'd14
`define POS_PROTO 6'd23
`define POS_DIP 6'd30
`define POS_ICMP_TYPE 6'd34
`define POS_ICMP_CODE 6'd35
`define LOCAL_IP_RST 32'h00000000
`endif

// *** slow_port_echo_filter_path.v ***
// slow-port receive filter, end-address queue, frame buffers and transmit sender
//
// Functional notes
// [R1] accept only frames matching ethertype, ip version, icmp protocol, local ip, echo request; a frame under 36 bytes is checked only on the bytes it has
// [R2] header comparison covers only the first 38 bytes of a frame
// [R3] frames are stored only while receive enable bit 0 is set
// [R4] clearing receive enable stops the path until set again
// [R5] queue status bit 15 reads zero while a frame is held, one when empty
// [R6] queue status bits 8:0 give the end address of the oldest frame
// [R7] writing one to command bit 1 drops the head queue entry
// [R8] received bytes are readable through the receive buffer region
// [R9] software fills the transmit buffer completely before starting a send
// [R10] writing a byte length starts sending that many buffer bytes to the mac
// [R11] software detects type 8 and writes type 0 into the reply
// [R12] software computes ip and icmp checksums; hardware inserts none
// [R13] software issues open or close, then polls connection status until it matches
// [R14] after engine reset, busy reads one during init; software waits for zero
// [R15] software supplies mode, addresses, ports and threshold before use
// [R16] user command bit 2 shows connection active
// [R17] user reset bit 16 shows ethernet link established
// [R18] software writes command 2 to open, 3 to close, 0 to send
// [R19] reset disables receive, empties the queue and idles the sender
//
// Our own choices: the strobed register port and the register addresses.
`include "slow_port_defines.vh"
module slow_port_echo_filter_path (
    input wire clk,
    input wire rst,
    input wire [15:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_last,
    output reg tx_valid,
    output reg [7:0] tx_data,
    output reg tx_last,
    input wire tx_ready,
    input wire offload_busy,
    input wire conn_on,
    input wire eth_link_pin,
    output reg [1:0] offload_cmd,
    output reg offload_cmd_valid,
    output reg user_rst,
    output wire irq
);

    ////////////////////////////////////////////////////////////////////////////
    // expected header byte at a frame position, {care, value}
    function [8:0] expected_byte;
        input [5:0] pos;
        input [31:0] ip;
        begin
            expected_byte = 9'h000;
            case (pos)
                `POS_ETYPE: expected_byte = {1'b1, `ETYPE_HI};
                `POS_ETYPE + 6'd1: expected_byte = {1'b1, `ETYPE_LO};
                `POS_VER: expected_byte = {1'b1, `IP_VER_HL};
                `POS_PROTO: expected_byte = {1'b1, `IP_PROTO_ICMP};
                `POS_DIP: expected_byte = {1'b1, ip[31:24]};
                `POS_DIP + 6'd1: expected_byte = {1'b1, ip[23:16]};
                `POS_DIP + 6'd2: expected_byte = {1'b1, ip[15:8]};
                `POS_DIP + 6'd3: expected_byte = {1'b1, ip[7:0]};
                `POS_ICMP_TYPE: expected_byte = {1'b1, `ICMP_ECHO_REQ};
                `POS_ICMP_CODE: expected_byte = {1'b1, `ICMP_CODE_ZERO};
                default: expected_byte = 9'h000;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // storage
    reg [7:0] rx_ram [0:511];
    reg [7:0] tx_ram [0:511];
    reg [8:0] queue_mem [0:15];

    reg rx_en_q;
    reg [31:0] local_ip_q;
    reg [2:0] irq_sts_q;
    reg [2:0] irq_mask_q;
    reg link_meta_q;
    reg link_q;
    reg [8:0] wr_ptr_q;
    reg [8:0] frame_start_q;
    reg [8:0] free_base_q;
    reg [5:0] hdr_pos_q;
    reg in_frame_q;
    reg keep_q;
    reg match_q;
    reg [4:0] q_wr_q;
    reg [4:0] q_rd_q;
    reg tx_busy_q;
    reg [8:0] tx_len_q;
    reg [8:0] tx_idx_q;

    wire wr_hit = reg_wr;
    // region selects look only at the upper address bits
    wire [15:0] rx_sel = `RX_BUF_BASE >> `BUF_SEL_LSB;
    wire [15:0] tx_sel = `TX_BUF_BASE >> `BUF_SEL_LSB;
    wire buf_rx = reg_addr[`BUF_SEL_MSB:`BUF_SEL_LSB] == rx_sel[4:0];
    wire buf_tx = reg_addr[`BUF_SEL_MSB:`BUF_SEL_LSB] == tx_sel[4:0];
    wire [8:0] buf_idx = reg_addr[10:2];
    // the extra pointer bit tells a full queue from an empty one
    wire q_empty = q_wr_q == q_rd_q;
    wire q_full = (q_wr_q[3:0] == q_rd_q[3:0]) && (q_wr_q[4] != q_rd_q[4]);
    wire [8:0] q_head = queue_mem[q_rd_q[3:0]];
    wire ack_wr = wr_hit && reg_addr == `OFS_RX_CMD && reg_wdata[`RX_ACK_BIT];
    wire pop = ack_wr && !q_empty; // [R7]

    ////////////////////////////////////////////////////////////////////////////
    // receive filter: first byte decides whether the frame is taken at all
    wire rx_first = rx_valid && !in_frame_q;
    wire take_now = rx_first ? rx_en_q : keep_q;
    wire take = take_now && rx_en_q; // [R3] [R4]
    wire [8:0] next_wr = wr_ptr_q + 9'd1;
    // one byte stays unused so a full buffer never looks empty
    wire overrun = next_wr == free_base_q;
    wire [5:0] pos_now = rx_first ? 6'd0 : hdr_pos_q;
    wire [8:0] exp_now = expected_byte(pos_now, local_ip_q);
    // bytes past the limit never reach the compare
    wire byte_ok = (pos_now >= `HDR_LIMIT) || !exp_now[8] || exp_now[7:0] == rx_data; // [R2]
    wire match_now = (rx_first ? 1'b1 : match_q) && byte_ok; // [R1]
    wire frame_done = rx_valid && rx_last && take && !overrun;
    wire push = frame_done && match_now && !q_full;
    wire drop_ev = rx_valid && rx_last && take && !push;

    // link state comes from the phy side, so synchronise it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            link_meta_q <= 1'b0;
            link_q <= 1'b0;
        end else begin
            link_meta_q <= eth_link_pin;
            link_q <= link_meta_q;
        end
    end

    // frame tracking and buffer write pointer
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= 9'h000; // [R19]
            frame_start_q <= 9'h000;
            in_frame_q <= 1'b0;
            keep_q <= 1'b0;
            match_q <= 1'b0;
            hdr_pos_q <= 6'd0;
        end else if (rx_valid) begin
            in_frame_q <= !rx_last;
            if (rx_first) begin
                frame_start_q <= wr_ptr_q;
            end
            keep_q <= take && !overrun;
            match_q <= match_now;
            // saturate so long frames do not wrap back into the header
            hdr_pos_q <= (pos_now >= `HDR_LIMIT) ? `HDR_LIMIT : pos_now + 6'd1; // [R2]
            if (push) begin
                wr_ptr_q <= next_wr;
            end else if (rx_last || !take || overrun) begin
                // rejected or aborted frame gives its space back
                wr_ptr_q <= rx_first ? wr_ptr_q : frame_start_q;
            end else begin
                wr_ptr_q <= next_wr;
            end
        end else if (!rx_en_q && in_frame_q) begin
            keep_q <= 1'b0;
        end
    end

    // receive buffer writes happen for every byte taken; a later reject only rewinds
    always @(posedge clk) begin
        if (rx_valid && take && !overrun) begin
            rx_ram[wr_ptr_q] <= rx_data;
        end
        if (push) begin
            queue_mem[q_wr_q[3:0]] <= wr_ptr_q;
        end
        if (wr_hit && buf_tx) begin
            tx_ram[buf_idx] <= reg_wdata[7:0]; // [R9]
        end
    end

    // end-address queue pointers and the oldest still owned address
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            q_wr_q <= 5'd0; // [R19]
            q_rd_q <= 5'd0;
            free_base_q <= 9'h000;
        end else begin
            if (push) begin
                q_wr_q <= q_wr_q + 5'd1;
            end
            if (pop) begin
                q_rd_q <= q_rd_q + 5'd1; // [R7]
                free_base_q <= q_head + 9'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit sender: data and last are registered, valid holds until ready
    // a length written while busy, or a zero length, is dropped rather than queued
    wire tx_start = wr_hit && reg_addr == `OFS_TX_LEN && !tx_busy_q && reg_wdata[8:0] != 9'h000;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_busy_q <= 1'b0; // [R19]
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
            tx_len_q <= 9'h000;
            tx_idx_q <= 9'h000;
        end else if (tx_start) begin
            // frame goes out as written, no checksum touched
            tx_busy_q <= 1'b1; // [R10] [R12]
            tx_valid <= 1'b1;
            tx_len_q <= reg_wdata[8:0];
            tx_idx_q <= 9'h000;
            tx_data <= tx_ram[0];
            tx_last <= reg_wdata[8:0] == 9'h001;
        end else if (tx_valid && tx_ready) begin
            if (tx_last) begin
                tx_valid <= 1'b0;
                tx_busy_q <= 1'b0;
                tx_last <= 1'b0;
            end else begin
                tx_idx_q <= tx_idx_q + 9'd1;
                tx_data <= tx_ram[tx_idx_q + 9'd1]; // [R10]
                tx_last <= tx_idx_q + 9'd2 == tx_len_q;
            end
        end
    end
    // done pulse only feeds the sticky status
    wire tx_done_ev = tx_valid && tx_ready && tx_last;

    ////////////////////////////////////////////////////////////////////////////
    // control registers and the offload command strobe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_en_q <= 1'b0; // [R19]
            local_ip_q <= `LOCAL_IP_RST;
            irq_mask_q <= 3'b000;
            user_rst <= 1'b0;
            offload_cmd <= 2'b00;
            offload_cmd_valid <= 1'b0;
        end else begin
            offload_cmd_valid <= 1'b0;
            if (wr_hit) begin
                case (reg_addr)
                    `OFS_RX_CMD: rx_en_q <= reg_wdata[`RX_EN_BIT]; // [R3] [R4]
                    `OFS_LOCAL_IP: local_ip_q <= reg_wdata;
                    `OFS_IRQ_MASK: irq_mask_q <= reg_wdata[2:0];
                    `OFS_USER_RST: user_rst <= reg_wdata[`USER_RST_BIT];
                    `OFS_OFFLOAD_CMD: begin
                        offload_cmd <= reg_wdata[1:0]; // [R18]
                        offload_cmd_valid <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // sticky events; a set in the clearing read cycle survives
    wire sts_rd = reg_rd && reg_addr == `OFS_IRQ_STS;
    wire [2:0] irq_set = {drop_ev, tx_done_ev, push};
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_sts_q <= 3'b000;
        end else begin
            irq_sts_q <= (sts_rd ? 3'b000 : irq_sts_q) | irq_set;
        end
    end
    assign irq = |(irq_sts_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // read data one cycle after the strobe; unmapped offsets read zero
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= 32'h00000000;
            if (buf_rx) begin
                reg_rdata <= {24'h000000, rx_ram[buf_idx]}; // [R8]
            end else if (buf_tx) begin
                reg_rdata <= {24'h000000, tx_ram[buf_idx]};
            end else begin
                case (reg_addr)
                    `OFS_RX_CMD: reg_rdata <= {31'h00000000, rx_en_q};
                    // empty flag plus oldest end address
                    `OFS_RX_QSTS: reg_rdata <= {16'h0000, q_empty, 6'h00, q_empty ? 9'h000 : q_head}; // [R5] [R6]
                    `OFS_TX_LEN: reg_rdata <= {16'h0000, tx_busy_q, 6'h00, tx_len_q};
                    `OFS_OFFLOAD_CMD: reg_rdata <= {31'h00000000, offload_busy}; // [R14]
                    `OFS_USER_CMD: reg_rdata <= {29'h00000000, conn_on, 2'b00}; // [R16]
                    `OFS_USER_RST: reg_rdata <= {15'h0000, link_q, 15'h0000, user_rst}; // [R17]
                    `OFS_LOCAL_IP: reg_rdata <= local_ip_q;
                    `OFS_IRQ_STS: reg_rdata <= {29'h00000000, irq_sts_q};
                    `OFS_IRQ_MASK: reg_rdata <= {29'h00000000, irq_mask_q};
                    default: reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // slow_port_echo_filter_path

// *** slow_port_echo_filter_path_properties.sv ***
// port checker of the slow-port echo path
module slow_port_checker (
    input logic clk,
    input logic rst,
    input logic [15:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [31:0] reg_rdata,
    input logic tx_valid,
    input logic [7:0] tx_data,
    input logic tx_last,
    input logic tx_ready,
    input logic offload_busy,
    input logic conn_on,
    input logic eth_link_pin,
    input logic [1:0] offload_cmd,
    input logic offload_cmd_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    // single clock, all checks off in reset
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    cmd_pulse_a: assert property (reg_wr && reg_addr == 16'h000c
        |=> offload_cmd_valid && offload_cmd == $past(reg_wdata[1:0])) else $error("command lost");
    cmd_cause_a: assert property (offload_cmd_valid
        |-> $past(reg_wr) && $past(reg_addr) == 16'h000c) else $error("stray command");
    tx_hold_a: assert property (tx_valid && !tx_ready
        |=> tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("byte not held");
    tx_end_a: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid) else $error("send overran");
    tx_start_a: assert property (reg_wr && reg_addr == 16'h0008 && reg_wdata[8:0] != 9'h0
        && !tx_valid && !$past(tx_valid) |=> tx_valid) else $error("send not started");
    conn_read_a: assert property (reg_rd && reg_addr == 16'h0010
        |=> reg_rdata == {29'h0, $past(conn_on), 2'h0}) else $error("conn flag wrong");
    busy_read_a: assert property (reg_rd && reg_addr == 16'h000c
        |=> reg_rdata[0] == $past(offload_busy)) else $error("busy flag wrong");
    // link pin passes two flops, so it must be steady and out of reset for three edges
    link_read_a: assert property (reg_rd && reg_addr == 16'h0014 && !$past(rst) && !$past(rst, 2)
        && $stable(eth_link_pin) && eth_link_pin == $past(eth_link_pin, 2)
        |=> reg_rdata[16] == $past(eth_link_pin)) else $error("link flag wrong");
endmodule // slow_port_checker

bind slow_port_echo_filter_path slow_port_checker checker_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .tx_valid, .tx_data, .tx_last, .tx_ready, .offload_busy, .conn_on, .eth_link_pin,
    .offload_cmd, .offload_cmd_valid);

// *** mac_model.sv ***
// behavioural ethernet mac on the far side of the slow port
module mac_model (
    input logic clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    input logic tx_valid,
    input logic [7:0] tx_data,
    input logic tx_last,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] fr [0:63];
    logic [7:0] got [0:15];
    logic slow = 1'b0;
    int cnt = 0;
    int last_at = 0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        tx_ready = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // echo request for the given address, other bytes counting up
    task automatic build(input logic [31:0] ip);
        for (int i = 0; i < 64; i++) fr[i] = i[7:0];
        {fr[12], fr[13], fr[14], fr[23]} = 32'h08004501;
        {fr[30], fr[31], fr[32], fr[33]} = ip;
        {fr[34], fr[35]} = 16'h0800;
    endtask
    // one byte per edge; idle line shows the inverse, never a stale byte
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= fr[i];
            rx_last <= (i == n - 1);
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~rx_data;
    endtask
    ////////////////////////////////////////////////////////////////
    // takes bytes; slow mode stalls every other cycle
    always @(posedge clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready) begin
            got[cnt[3:0]] <= tx_data;
            cnt <= cnt + 1;
            if (tx_last) last_at <= cnt + 1;
        end
    end
endmodule // mac_model

// *** test_slow_port_echo_filter_path.sv ***
// self-checking bench of the slow-port echo path
`include "slow_port_defines.vh"
module test_slow_port_echo_filter_path;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] IP = 32'hc0a80a05;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, offload_busy = 1'b1, conn_on = 1'b0, eth_link_pin = 1'b0;
    logic [15:0] reg_addr = 16'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic rx_valid, rx_last, tx_valid, tx_last, tx_ready, offload_cmd_valid, user_rst, irq;
    logic [7:0] rx_data, tx_data;
    logic [1:0] offload_cmd;
    int bad_count = 0;
    int num_checks = 0;
    int pos [8] = '{12, 13, 14, 23, 30, 33, 34, 35};
    slow_port_echo_filter_path DUT (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_valid,
        .rx_data, .rx_last, .tx_valid, .tx_data, .tx_last, .tx_ready, .offload_busy, .conn_on, .eth_link_pin,
        .offload_cmd, .offload_cmd_valid, .user_rst, .irq);
    mac_model mac (.clk, .rx_valid, .rx_data, .rx_last, .tx_valid, .tx_data, .tx_last, .tx_ready);
    initial forever #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    // register bus: strobes one cycle, read data checked in the cycle after
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, exp);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(`OFS_RX_QSTS, 32'hffffffff, 32'h8000);
        rd(`OFS_TX_LEN, 32'h8000, 32'h0);
        rd(`OFS_RX_CMD, 32'hffffffff, 32'h0);
        $display("reset test done");
        @(posedge clk) conn_on <= 1'b1;
        eth_link_pin <= 1'b1;
        rd(`OFS_OFFLOAD_CMD, 32'h1, 32'h1);
        @(posedge clk) offload_busy <= 1'b0;
        rd(`OFS_OFFLOAD_CMD, 32'h1, 32'h0);
        rd(`OFS_USER_CMD, 32'hffffffff, 32'h4);
        wr(`OFS_USER_RST, 32'h1);
        #1 chk(user_rst, 1'b1);
        rd(`OFS_USER_RST, 32'h10001, 32'h10001);
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_OFFLOAD_CMD, c);
            #1 chk(offload_cmd, c);
        end
        // last command was a close; the engine drops the connection and software polls it
        conn_on <= 1'b0;
        rd(`OFS_USER_CMD, 32'h4, 32'h0);
        $display("status test done");
        // receive: off, then on, then each header field spoiled
        wr(`OFS_IRQ_MASK, 32'h7);
        wr(`OFS_LOCAL_IP, IP);
        mac.build(IP);
        mac.send(42);
        rd(`OFS_RX_QSTS, 32'h8000, 32'h8000);
        wr(`OFS_RX_CMD, 32'h1);
        mac.send(42);
        rd(`OFS_RX_QSTS, 32'hffffffff, 32'd41);
        chk(irq, 1'b1);
        rd(`RX_BUF_BASE + 16'd120, 32'hff, IP[31:24]);
        rd(`RX_BUF_BASE + 16'd136, 32'hff, 32'h8);
        rd(`OFS_IRQ_STS, 32'h1, 32'h1);
        rd(`OFS_IRQ_STS, 32'h7, 32'h0);
        chk(irq, 1'b0);
        foreach (pos[i]) begin
            mac.build(IP);
            mac.fr[pos[i]] = ~mac.fr[pos[i]];
            mac.send(42);
            rd(`OFS_RX_QSTS, 32'hffffffff, 32'd41);
        end
        // a byte past the header limit must not matter
        mac.build(IP);
        mac.fr[40] = 8'h5a;
        mac.send(42);
        wr(`OFS_RX_CMD, 32'h3);
        rd(`OFS_RX_QSTS, 32'hffffffff, 32'd83);
        wr(`OFS_RX_CMD, 32'h3);
        rd(`OFS_RX_QSTS, 32'h8000, 32'h8000);
        wr(`OFS_RX_CMD, 32'h0);
        mac.send(42);
        rd(`OFS_RX_QSTS, 32'h8000, 32'h8000);
        $display("receive test done");
        // send five bytes to a stalling mac; a second length while busy is ignored
        for (int i = 0; i < 5; i++) wr(`TX_BUF_BASE + 16'(4 * i), 32'ha0 + i);
        mac.slow <= 1'b1;
        wr(`OFS_TX_LEN, 32'd5);
        wr(`OFS_TX_LEN, 32'd3);
        for (int i = 0; i < 100 && !(mac.cnt == 5 && !tx_valid); i++) @(posedge clk);
        if (mac.cnt != 5 || tx_valid) begin
            bad_count++;
            $display("ERROR %0t: send timed out", $time);
            end_sim();
        end
        rd(`OFS_TX_LEN, 32'h81ff, 32'd5);
        chk(mac.cnt, 5);
        chk(mac.last_at, 5);
        for (int i = 0; i < 5; i++) chk(mac.got[i], 32'ha0 + i);
        wr(`OFS_IRQ_MASK, 32'h0);
        #1 chk(irq, 1'b0);
        // drops, accepted frame and send done are all still pending
        rd(`OFS_IRQ_STS, 32'h7, 32'h7);
        $display("transmit test done");
        // receive again after re-enable, then a second reset must drop the held frame
        wr(`OFS_RX_CMD, 32'h1);
        mac.send(42);
        rd(`OFS_RX_QSTS, 32'hffffffff, 32'd125);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(`OFS_RX_QSTS, 32'hffffffff, 32'h8000);
        rd(`OFS_RX_CMD, 32'h1, 32'h0);
        $display("second reset test done");
        end_sim();
    end
endmodule // test_slow_port_echo_filter_path
